// >>> src/lom_pkg.sv
// Constants and types shared by the line output mixer register bank
`default_nettype none
package lom_pkg;
    // Register bus geometry
    localparam int unsigned ADDR_W = 7;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned VOL_W  = 7;
    localparam int unsigned LVL_W  = 4;
    localparam int unsigned NPATH  = 12;

    // Register addresses, page 0
    localparam logic [6:0] LINE2_LEFT_TO_LEFT_OUT  = 7'h50;
    localparam logic [6:0] GAIN_LEFT_TO_LEFT_OUT   = 7'h51;
    localparam logic [6:0] CONV_LEFT_TO_LEFT_OUT   = 7'h52;
    localparam logic [6:0] LINE2_RIGHT_TO_LEFT_OUT = 7'h53;
    localparam logic [6:0] GAIN_RIGHT_TO_LEFT_OUT  = 7'h54;
    localparam logic [6:0] CONV_RIGHT_TO_LEFT_OUT  = 7'h55;
    localparam logic [6:0] LEFT_OUT_LEVEL          = 7'h56;
    localparam logic [6:0] LINE2_LEFT_TO_RIGHT_OUT = 7'h57;
    localparam logic [6:0] GAIN_LEFT_TO_RIGHT_OUT  = 7'h58;
    localparam logic [6:0] CONV_LEFT_TO_RIGHT_OUT  = 7'h59;
    localparam logic [6:0] LINE2_RIGHT_TO_RIGHT_OUT = 7'h5A;
    localparam logic [6:0] GAIN_RIGHT_TO_RIGHT_OUT = 7'h5B;
    localparam logic [6:0] CONV_RIGHT_TO_RIGHT_OUT = 7'h5C;

    // Routing register fields
    localparam int unsigned ROUTE_EN_BIT = 7;
    localparam int unsigned VOL_MSB      = 6;

    // Level register fields
    localparam int unsigned LVL_MSB      = 7;
    localparam int unsigned LVL_LSB      = 4;
    localparam int unsigned UNMUTE_BIT   = 3;
    localparam int unsigned RSVD_BIT     = 2;
    localparam int unsigned PEND_BIT     = 1;
    localparam int unsigned PWR_BIT      = 0;

    // Index offset of right output paths in the path array
    localparam logic [3:0] RIGHT_BASE_IDX = 4'h6;

    // One source-to-output path setting
    typedef struct packed {
        logic             en;
        logic [VOL_W-1:0] vol;
    } lom_path_s;

    // Whole state of the register bank
    typedef struct packed {
        lom_path_s [NPATH-1:0] path;
        logic [LVL_W-1:0]      level;
        logic                  unmute;
        logic [1:0]            pend_sync;
        logic [1:0]            pwr_sync;
        logic [DATA_W-1:0]     rdata;
        logic                  rvalid;
    } lom_state_s;

    // Reset image: all paths off, muted, gain pending, driver down
    localparam lom_state_s STATE_RST = '{
        path:      '0,
        level:     4'h0,
        unmute:    1'b0,
        pend_sync: 2'h3,
        pwr_sync:  2'h0,
        rdata:     8'h00,
        rvalid:    1'b0
    };
endpackage : lom_pkg
`default_nettype wire

// >>> src/lom_regs.sv
// Line output mixer control register bank
//
// How it works
// - Bit 7 of each routing register connects its source; resets disconnected.
// - Bits 6..0 of each routing register hold a volume code, reset zero.
// - Addresses 80..85 route six sources to the left line output.
// - Addresses 87..89 route left-side sources to the right line output.
// - Level register bits 7..4 set output level 0..9 dB, reset 0000.
// - Level register bit 3 unmutes the left output; resets muted.
// - Level bit 2 is reserved, reads zero, software leaves it alone.
// - Level bit 1 reads one while gains are pending; resets to one.
// - Level bit 0 reads one when the left driver is powered.
// - Addresses 90..92 route right-side sources to the right output.
//
// Register map, page 0, one byte per address
//   0x50..0x55  sources to the left line output pair, slots 0..5
//   0x56        left output level, mute and live status
//   0x57..0x5C  sources to the right line output pair, slots 6..11
//   other       reads return zero, writes are dropped
//
// Path slots and the source that each one carries
//   0   second line input left    to the left output pair
//   1   left input gain stage     to the left output pair
//   2   left converter path       to the left output pair
//   3   second line input right   to the left output pair
//   4   right input gain stage    to the left output pair
//   5   right converter path      to the left output pair
//   6   second line input left    to the right output pair
//   7   left input gain stage     to the right output pair
//   8   left converter path       to the right output pair
//   9   second line input right   to the right output pair
//   10  right input gain stage    to the right output pair
//   11  right converter path      to the right output pair
//
// Routing byte: [7] source connected, [6:0] volume code
// Level byte:   [7:4] level code, [3] unmute, [2] reserved,
//               [1] gain pending, [0] driver powered
//
// Register port: a strobe is taken at a rising clock edge. A write
// lands at that edge; a read answers one cycle later with a one-cycle
// valid pulse, and the read data holds until the next read. Strobes
// may come back to back. A read and a write to one address in the
// same cycle return the old value, as the read image comes from the
// current state, not the next one.
//
// The status inputs are not timed to this clock, so each passes two
// flops before anything reads it. A read therefore shows a status
// change two edges after it happens; the pending bit starts high so
// that software never sees a false settled state out of reset.
//
// Limitations: reserved level codes are stored and driven as written,
// so keeping them out is up to software. Page selection lives outside
// this bank, which only decodes page 0 addresses.
`default_nettype none
module lom_regs
(
    // Clock and reset
    input  wire logic                     CLK,
    input  wire logic                     RST,
    // Register port
    input  wire logic [lom_pkg::ADDR_W-1:0] REG_ADDR,
    input  wire logic                     REG_WR,
    input  wire logic [lom_pkg::DATA_W-1:0] REG_WDATA,
    input  wire logic                     REG_RD,
    output logic      [lom_pkg::DATA_W-1:0] REG_RDATA,
    output logic                          REG_RVALID,
    // Analog status, asynchronous
    input  wire logic                     GAIN_PENDING,
    input  wire logic                     DRIVER_POWERED,
    // Analog controls
    output lom_pkg::lom_path_s [lom_pkg::NPATH-1:0] PATH,
    output logic      [lom_pkg::LVL_W-1:0]  OUT_LEVEL,
    output logic                          OUT_UNMUTE
);

    lom_pkg::lom_state_s st_r;
    lom_pkg::lom_state_s st_nxt;

    // True when the address selects one of the twelve routing registers;
    // the level register in the middle of the range is not one of them
    function automatic logic is_route(input logic [6:0] a);
        logic hit;
        hit = 1'b0;
        case (a)
            lom_pkg::LINE2_LEFT_TO_LEFT_OUT,
            lom_pkg::GAIN_LEFT_TO_LEFT_OUT,
            lom_pkg::CONV_LEFT_TO_LEFT_OUT,
            lom_pkg::LINE2_RIGHT_TO_LEFT_OUT,
            lom_pkg::GAIN_RIGHT_TO_LEFT_OUT,
            lom_pkg::CONV_RIGHT_TO_LEFT_OUT:
                hit = 1'b1;
            lom_pkg::LINE2_LEFT_TO_RIGHT_OUT,
            lom_pkg::GAIN_LEFT_TO_RIGHT_OUT,
            lom_pkg::CONV_LEFT_TO_RIGHT_OUT:
                hit = 1'b1;
            lom_pkg::LINE2_RIGHT_TO_RIGHT_OUT,
            lom_pkg::GAIN_RIGHT_TO_RIGHT_OUT,
            lom_pkg::CONV_RIGHT_TO_RIGHT_OUT:
                hit = 1'b1;
            default:
                hit = 1'b0;
        endcase
        is_route = hit;
    endfunction : is_route

    // Slot of a routing register in the path array; the level register
    // sits between the outputs, so slots are listed rather than computed
    function automatic logic [3:0] route_idx(input logic [6:0] a);
        logic [3:0] idx;
        idx = 4'h0;
        case (a)
            lom_pkg::LINE2_LEFT_TO_LEFT_OUT:
                idx = 4'h0;
            lom_pkg::GAIN_LEFT_TO_LEFT_OUT:
                idx = 4'h1;
            lom_pkg::CONV_LEFT_TO_LEFT_OUT:
                idx = 4'h2;
            lom_pkg::LINE2_RIGHT_TO_LEFT_OUT:
                idx = 4'h3;
            lom_pkg::GAIN_RIGHT_TO_LEFT_OUT:
                idx = 4'h4;
            lom_pkg::CONV_RIGHT_TO_LEFT_OUT:
                idx = 4'h5;
            lom_pkg::LINE2_LEFT_TO_RIGHT_OUT:
                idx = lom_pkg::RIGHT_BASE_IDX;
            lom_pkg::GAIN_LEFT_TO_RIGHT_OUT:
                idx = lom_pkg::RIGHT_BASE_IDX + 4'h1;
            lom_pkg::CONV_LEFT_TO_RIGHT_OUT:
                idx = lom_pkg::RIGHT_BASE_IDX + 4'h2;
            lom_pkg::LINE2_RIGHT_TO_RIGHT_OUT:
                idx = lom_pkg::RIGHT_BASE_IDX + 4'h3;
            lom_pkg::GAIN_RIGHT_TO_RIGHT_OUT:
                idx = lom_pkg::RIGHT_BASE_IDX + 4'h4;
            lom_pkg::CONV_RIGHT_TO_RIGHT_OUT:
                idx = lom_pkg::RIGHT_BASE_IDX + 4'h5;
            default:
                idx = 4'h0;
        endcase
        route_idx = idx;
    endfunction : route_idx

    // Read image of the level register: stored level and mute on top,
    // reserved bit forced low, live status from the second sync stage
    function automatic logic [7:0] level_image(input lom_pkg::lom_state_s s);
        logic [7:0] img;
        img = 8'h00;
        img[lom_pkg::LVL_MSB:lom_pkg::LVL_LSB] = s.level;
        img[lom_pkg::UNMUTE_BIT] = s.unmute;
        img[lom_pkg::RSVD_BIT]   = 1'b0;
        img[lom_pkg::PEND_BIT]   = s.pend_sync[1];
        img[lom_pkg::PWR_BIT]    = s.pwr_sync[1];
        level_image = img;
    endfunction : level_image

    // Next state: status sync, register writes, read capture
    always_comb
    begin
        logic [7:0] lvl_rd;
        lvl_rd = 8'h00;
        st_nxt = st_r;
        // Two stages: status comes from the analog side, off this clock
        st_nxt.pend_sync = {st_r.pend_sync[0], GAIN_PENDING};
        st_nxt.pwr_sync  = {st_r.pwr_sync[0], DRIVER_POWERED};
        st_nxt.rvalid    = 1'b0;

        // Writes; only the level and mute fields of 0x56 are stored
        if (REG_WR)
        begin
            if (is_route(REG_ADDR))
            begin
                st_nxt.path[route_idx(REG_ADDR)] = REG_WDATA;
            end
            else if (REG_ADDR == lom_pkg::LEFT_OUT_LEVEL)
            begin
                // Reserved codes are stored as written, not clamped
                st_nxt.level  = REG_WDATA[lom_pkg::LVL_MSB:
                                          lom_pkg::LVL_LSB];
                st_nxt.unmute = REG_WDATA[lom_pkg::UNMUTE_BIT];
                // Bits 2..0 dropped: status is not writable
            end
        end

        // Level register read image, taken from the current state so a
        // write in the same cycle is not seen until the next read
        lvl_rd = level_image(st_r);

        // Reads answer one cycle later; unmapped addresses read zero so
        // that software probing the map never sees a stale byte
        if (REG_RD)
        begin
            st_nxt.rvalid = 1'b1;
            if (is_route(REG_ADDR))
            begin
                st_nxt.rdata = st_r.path[route_idx(REG_ADDR)];
            end
            else if (REG_ADDR == lom_pkg::LEFT_OUT_LEVEL)
            begin
                st_nxt.rdata = lvl_rd;
            end
            else
            begin
                st_nxt.rdata = 8'h00;
            end
        end
    end

    // State register; reset loads only the constant reset image, so
    // every path starts disconnected, the output muted and the status
    // stages at their power-on values
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            st_r <= lom_pkg::STATE_RST;
        else
            st_r <= st_nxt;
    end

    // Outputs straight from the state flops
    assign REG_RDATA  = st_r.rdata;
    assign REG_RVALID = st_r.rvalid;
    assign PATH       = st_r.path;
    assign OUT_LEVEL  = st_r.level;
    assign OUT_UNMUTE = st_r.unmute;

endmodule : lom_regs
`default_nettype wire

// >>> bench/lom_regs_props.sv
// Port-level checks of the line output mixer register bank
`default_nettype none
module lom_regs_props
(
    input wire logic CLK, RST, REG_WR, REG_RD, REG_RVALID, OUT_UNMUTE,
    input wire logic [6:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA, REG_RDATA,
    input wire logic [3:0] OUT_LEVEL,
    input wire lom_pkg::lom_path_s [11:0] PATH
);
timeunit 1ns;
timeprecision 100ps;
default clocking @(posedge CLK); endclocking
default disable iff (RST);
a_rd_answer:
assert property (REG_RD |=> REG_RVALID) else $error("no read answer");
a_rd_nospur:
assert property (!REG_RD |=> !REG_RVALID) else $error("stray answer");
a_path0_wr:
assert property (REG_WR && REG_ADDR == 7'h50 |=> PATH[0] == $past(REG_WDATA))
    else $error("path 0 lost");
a_path6_wr:
assert property (REG_WR && REG_ADDR == 7'h57 |=> PATH[6] == $past(REG_WDATA))
    else $error("path 6 lost");
a_path11_wr:
assert property (REG_WR && REG_ADDR == 7'h5C |=> PATH[11] == $past(REG_WDATA))
    else $error("path 11 lost");
a_lvl_wr:
assert property (REG_WR && REG_ADDR == 7'h56
    |=> {OUT_LEVEL, OUT_UNMUTE} == $past(REG_WDATA[7:3])) else $error("lvl");
a_lvl_hold:
assert property (!REG_WR |=> $stable({OUT_LEVEL, OUT_UNMUTE}))
    else $error("level moved");
a_rsvd_zero:
assert property (REG_RD && REG_ADDR == 7'h56 |=> !REG_RDATA[2])
    else $error("reserved set");
a_hole_zero:
assert property (REG_RD && REG_ADDR == 7'h5D |=> REG_RDATA == 8'h00)
    else $error("hole not zero");
endmodule : lom_regs_props
bind lom_regs lom_regs_props i_props(.CLK, .RST, .REG_WR, .REG_RD,
    .REG_RVALID, .OUT_UNMUTE, .REG_ADDR, .REG_WDATA, .REG_RDATA,
    .OUT_LEVEL, .PATH);
`default_nettype wire

// >>> bench/lom_analog.sv
// Analog stand-in reporting gain settling and driver power
`default_nettype none
module lom_analog
(
    input  wire logic CLK,
    input  wire logic SETTLE,
    output logic      PEND,
    output logic      PWR
);
timeunit 1ns;
timeprecision 1ns;
// Off the bank's edge, so the sync stages see a true async change
always @(negedge CLK)
begin
    PEND <= !SETTLE;
    PWR  <= SETTLE;
end
endmodule : lom_analog
`default_nettype wire

// >>> bench/tb.sv
// Self-checking testbench of the line output mixer register bank
`default_nettype none
module tb;
timeunit 1ns;
timeprecision 100ps;
logic CLK = 0, RST = 1, wr = 0, rd = 0, settle = 0, rv, gp, dp, lm;
logic [6:0] addr = 0;
logic [7:0] wd = 0, rdat, d;
logic [3:0] lvl;
lom_pkg::lom_path_s [11:0] path;
int n_errors = 0, n_compared = 0;
initial forever #12.5 CLK = ~CLK;
lom_regs i_lom_regs(.CLK(CLK), .RST(RST), .REG_ADDR(addr), .REG_WR(wr),
    .REG_WDATA(wd), .REG_RD(rd), .REG_RDATA(rdat), .REG_RVALID(rv),
    .GAIN_PENDING(gp), .DRIVER_POWERED(dp), .PATH(path),
    .OUT_LEVEL(lvl), .OUT_UNMUTE(lm));
lom_analog i_lom_analog(.CLK(CLK), .SETTLE(settle), .PEND(gp), .PWR(dp));
task chk(string n, logic [7:0] s, e);
    n_compared++;
    if (s !== e)
    begin
        n_errors++;
        $display("unexpected %s exp %h got %h", n, e, s);
    end
endtask : chk
// One access, strobe held for exactly one edge
task acc(logic w, logic [6:0] a, logic [7:0] v);
    @(negedge CLK);
    {wr, rd, addr, wd} = {w, !w, a, v};
    @(negedge CLK);
    {wr, rd} = 2'b00;
    if (!w) chk("rvalid", {7'h00, rv}, 8'h01);
endtask : acc
function logic [6:0] adr(int i);
    return 7'(i < 6 ? 80 + i : 81 + i);
endfunction : adr
task final_report;
    if (n_errors == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
endtask : final_report
// Whole run needs little over a hundred cycles
initial
begin
    #100000;
    n_errors++;
    final_report;
end
initial
begin
    void'($urandom(32'h7b96));
    repeat (16) @(posedge CLK);
    @(negedge CLK) RST = 0;
    for (int i = 0; i < 13; i++)
    begin
        acc(0, i < 12 ? adr(i) : 7'h56, 0);
        chk("reset", rdat, i < 12 ? 8'h00 : 8'h02);
    end
    for (int i = 0; i < 12; i++)
    begin
        d = i == 11 ? 8'hFF : 8'($urandom);
        acc(1, adr(i), d);
        chk("path", path[i], d);
        acc(0, adr(i), 0);
        chk("route", rdat, d);
    end
    settle = 1;
    repeat (4) @(posedge CLK);
    // Reserved level codes and the reserved bit are never written
    for (int k = 0; k < 2; k++)
    begin
        d = {k ? 4'h9 : 4'($urandom_range(9)), 1'($urandom), 3'h3};
        acc(1, 7'h56, d);
        acc(0, 7'h56, 0);
        chk("level", rdat, {d[7:3], 3'h1});
        chk("outs", {3'h0, lvl, lm}, {3'h0, d[7:3]});
    end
    acc(0, 7'h5D, 0);
    chk("hole", rdat, 8'h00);
    // Reset in mid-run: stored fields clear, pending restarts high
    @(negedge CLK) RST = 1;
    @(negedge CLK) RST = 0;
    chk("rst_path", path[11], 8'h00);
    chk("rst_lvl", {3'h0, lvl, lm}, 8'h00);
    acc(0, 7'h56, 0);
    chk("rst_stat", rdat, 8'h02);
    final_report;
end
endmodule : tb
`default_nettype wire
